// ---- design/dac_ctrl.v ----
// Dual 12-bit converter digital output control
`timescale 1ns/1ps
`include "dac_regs.vh"
module dac_ctrl #(
	parameter W = `DAC_DATA_W,
	parameter LAT = `DAC_LATENCY,
	parameter DEPTH = `DAC_FIFO_DEPTH,
	parameter SETTLE = `DAC_FMT_SETTLE
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Quantised samples from the converter cores
	input wire [W-1:0] samp_a_i,
	input wire [W-1:0] samp_b_i,
	// Control pins
	input wire chan_a_drive_disable_i,
	input wire chan_b_drive_disable_i,
	input wire powerdown_request_i,
	input wire format_select_i,
	// Output buses, enable low while driven
	output reg [W-1:0] data_a_o,
	output reg [W-1:0] data_a_oe_n_o,
	output reg [W-1:0] data_b_o,
	output reg [W-1:0] data_b_oe_n_o,
	// Status
	output reg valid_a_o,
	output reg valid_b_o,
	output reg powered_down_o,
	output reg fmt_settling_o
);
	reg rst_s1_q, rst_q;
	reg [3:0] pin_s1_q, pin_q;
	reg [W-1:0] pipe_a_q [0:LAT-1];
	reg [W-1:0] pipe_b_q [0:LAT-1];
	reg [LAT-1:0] pv_q;
	reg fmt_last_q;
	reg [3:0] settle_q;
	wire dis_a, dis_b, pd, fmt;
	wire fifo_in_ready, fifo_out_valid;
	wire [2*W-1:0] fifo_out;
	wire [W-1:0] word_a, word_b;
	wire run_w;
	integer i;
	// Power state: one-hot, the pipeline refills after every wake-up
	localparam [2:0] ST_RUN = 3'b001;
	localparam [2:0] ST_DOWN = 3'b010;
	localparam [2:0] ST_FILL = 3'b100;
	localparam [3:0] SETTLE_LD = SETTLE;
	reg [2:0] st_q;
	reg [2:0] st_d;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_q <= rst_s1_q;
		end
	end
	// Pins are asynchronous to the sample clock
	always @(posedge clk_i or negedge rst_q) begin
		if (!rst_q) begin
			pin_s1_q <= 4'hF;
			pin_q <= 4'hF;
		end else begin
			pin_s1_q <= {chan_a_drive_disable_i, chan_b_drive_disable_i,
				powerdown_request_i, format_select_i};
			pin_q <= pin_s1_q;
		end
	end
	assign dis_a = pin_q[3];
	assign dis_b = pin_q[2];
	assign pd = pin_q[1];
	assign fmt = pin_q[0];
	// Pipeline ignores drive-disable entirely
	always @(posedge clk_i) begin
		pipe_a_q[0] <= samp_a_i;
		pipe_b_q[0] <= samp_b_i;
		for (i = 1; i < LAT; i = i + 1) begin
			pipe_a_q[i] <= pipe_a_q[i-1];
			pipe_b_q[i] <= pipe_b_q[i-1];
		end
	end
	always @(posedge clk_i or negedge rst_q) begin
		if (!rst_q) begin
			pv_q <= {LAT{1'b0}};
		end else if (pd) begin
			pv_q <= {LAT{1'b0}};
		end else begin
			pv_q <= {pv_q[LAT-2:0], 1'b1};
		end
	end
	always @* begin
		st_d = st_q;
		case (st_q)
			ST_RUN: begin
				if (pd) begin
					st_d = ST_DOWN;
				end
			end
			ST_DOWN: begin
				if (!pd) begin
					st_d = ST_FILL;
				end
			end
			ST_FILL: begin
				if (pd) begin
					st_d = ST_DOWN;
				end else if (pv_q[LAT-1]) begin
					st_d = ST_RUN;
				end
			end
			default: begin
				st_d = ST_DOWN;
			end
		endcase
	end
	// Reset counts as powered down, so the first words wait for a full refill
	always @(posedge clk_i or negedge rst_q) begin
		if (!rst_q) begin
			st_q <= ST_DOWN;
		end else begin
			st_q <= st_d;
		end
	end
	assign run_w = st_q[0];
	// FIFO sits before the output register; its drain side is tied ready, so it never stalls on power-down
	dac_fifo #(.W(2*W), .DEPTH(DEPTH), .AW(3)) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_q),
		.in_valid_i(pv_q[LAT-1] && !pd),
		.in_ready_o(fifo_in_ready),
		.in_data_i({pipe_a_q[LAT-1], pipe_b_q[LAT-1]}),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(1'b1),
		.out_data_o(fifo_out)
	);
	// Top bit flip turns offset binary into two's complement
	assign word_a = {fifo_out[2*W-1] ^ fmt, fifo_out[2*W-2:W]};
	assign word_b = {fifo_out[W-1] ^ fmt, fifo_out[W-2:0]};
	always @(posedge clk_i or negedge rst_q) begin
		if (!rst_q) begin
			fmt_last_q <= 1'b0;
			settle_q <= 4'h0;
		end else begin
			fmt_last_q <= fmt;
			if (fmt != fmt_last_q) begin
				settle_q <= SETTLE_LD;
			end else if (settle_q != 4'h0) begin
				settle_q <= settle_q - 4'h1;
			end
		end
	end
	// Status flags
	always @(posedge clk_i or negedge rst_q) begin
		if (!rst_q) begin
			powered_down_o <= 1'b1;
			fmt_settling_o <= 1'b0;
		end else begin
			powered_down_o <= pd;
			fmt_settling_o <= (settle_q != 4'h0);
		end
	end
	// Channel A output stage
	always @(posedge clk_i or negedge rst_q) begin
		if (!rst_q) begin
			data_a_o <= `DAC_BAD_WORD;
			data_a_oe_n_o <= {W{1'b1}};
			valid_a_o <= 1'b0;
		end else begin
			data_a_oe_n_o <= {W{dis_a}};
			valid_a_o <= fifo_out_valid && run_w && !pd && !dis_a && fifo_in_ready;
			if (pd || !fifo_out_valid) begin
				data_a_o <= `DAC_BAD_WORD;
			end else begin
				data_a_o <= word_a;
			end
		end
	end
	// Channel B output stage, same timing as A so the pair stays aligned
	always @(posedge clk_i or negedge rst_q) begin
		if (!rst_q) begin
			data_b_o <= `DAC_BAD_WORD;
			data_b_oe_n_o <= {W{1'b1}};
			valid_b_o <= 1'b0;
		end else begin
			data_b_oe_n_o <= {W{dis_b}};
			valid_b_o <= fifo_out_valid && run_w && !pd && !dis_b && fifo_in_ready;
			if (pd || !fifo_out_valid) begin
				data_b_o <= `DAC_BAD_WORD;
			end else begin
				data_b_o <= word_b;
			end
		end
	end
endmodule

// ---- design/dac_fifo.v ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dac_fifo #(
	parameter W = 24,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Fill side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	// Drain side
	output reg out_valid_o,
	input wire out_ready_i,
	output reg [W-1:0] out_data_o
);
	reg [W-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire do_wr;
	wire do_rd;
	wire [AW:0] depth_w;
	assign depth_w = DEPTH;
	// Output register is not counted; DEPTH words fit in memory besides it
	assign in_ready_o = (cnt_q != depth_w);
	assign do_wr = in_valid_i && in_ready_o;
	assign do_rd = (cnt_q != {(AW+1){1'b0}}) && (!out_valid_o || out_ready_i);
	always @(posedge clk_i) begin
		if (do_wr) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			out_valid_o <= 1'b0;
			out_data_o <= {W{1'b0}};
		end else begin
			if (do_wr) begin
				wr_q <= (wr_q == DEPTH-1) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (do_rd) begin
				rd_q <= (rd_q == DEPTH-1) ? {AW{1'b0}} : rd_q + 1'b1;
				out_data_o <= mem_q[rd_q];
				out_valid_o <= 1'b1;
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
			if (do_wr && !do_rd) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (!do_wr && do_rd) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

// ---- design/dac_regs.vh ----
// Constants for the dual converter output control block
`ifndef DAC_REGS_VH
`define DAC_REGS_VH
`define DAC_DATA_W 12
`define DAC_LATENCY 6
`define DAC_FIFO_DEPTH 8
`define DAC_MSB 11
`define DAC_MID_SCALE 12'h800
`define DAC_BAD_WORD 12'hFFF
`define DAC_FMT_SETTLE 3
`define DAC_CLK_MIN_KHZ 100
`define DAC_CLK_MAX_KHZ 55000
`endif

// ---- verification/dac_ctrl_chk.sv ----
// Port checker for dac_ctrl
`timescale 1ns/1ps
module dac_ctrl_chk (
	input clk_i, input rst_n_i, input chan_a_drive_disable_i, input powerdown_request_i,
	input [11:0] data_a_o, input [11:0] data_a_oe_n_o,
	input [11:0] data_b_o, input [11:0] data_b_oe_n_o,
	input valid_a_o, input valid_b_o, input powered_down_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence float_held; chan_a_drive_disable_i [*4]; endsequence
	sequence pd_held; powered_down_o [*2]; endsequence
	oe_a_even_a: assert property (&data_a_oe_n_o || ~|data_a_oe_n_o) else $error("A mixed");
	oe_b_even_a: assert property (&data_b_oe_n_o || ~|data_b_oe_n_o) else $error("B mixed");
	float_a_a: assert property (float_held |-> &data_a_oe_n_o) else $error("A driven");
	pd_enter_a: assert property (powerdown_request_i |-> ##[1:4] powered_down_o) else $error("no pd");
	pd_quiet_a: assert property (pd_held |-> !valid_a_o && !valid_b_o) else $error("valid");
	pd_word_a: assert property (pd_held |-> &data_a_o && &data_b_o) else $error("word");
	drive_a_a: assert property (valid_a_o |-> ~|data_a_oe_n_o) else $error("A float");
	drive_b_a: assert property (valid_b_o |-> ~|data_b_oe_n_o) else $error("B float");
endmodule
bind dac_ctrl dac_ctrl_chk u_chk (.*);

// ---- verification/dac_ctrl_tb.sv ----
// Bench for dac_ctrl
`timescale 1ns/1ps
module dac_ctrl_tb;
	logic clk_i = 0, rst_n_i = 0, powerdown_request_i = 0;
	logic format_select_i = 0, chan_a_drive_disable_i = 0;
	logic chan_b_drive_disable_i = 0, valid_a_o, valid_b_o, powered_down_o, fmt_settling_o;
	logic [11:0] samp_a_i = 12'h800, samp_b_i = 12'h800, wa, data_a_o, data_b_o;
	logic [11:0] data_a_oe_n_o, data_b_oe_n_o;
	wire [11:0] pa = &data_a_oe_n_o ? 12'hZZZ : data_a_o;
	int error_cnt = 0, compares = 0;
	always #10 clk_i = ~clk_i;
	dac_ctrl DUT (.*);
	dac_rx_model RX (.clk_i(clk_i), .pd_i(powerdown_request_i), .v_i(valid_a_o),
		.p_i(pa), .w_o(wa));
	task chk(input string n, input logic [11:0] got, exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s exp %h got %h", n, exp, got);
		end
	endtask
	task complete_run;
		if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Outputs are read mid-cycle, away from the edge that launches them
	task mid;
		@(negedge clk_i);
	endtask
	task t_stream;
		cyc(20);
		samp_a_i <= 12'h123;
		cyc(5);
		mid;
		chk("A early", data_a_o, 12'h800);
		cyc(7);
		mid;
		chk("A word", wa, 12'h123);
		chk("B valid", {11'h000, valid_b_o}, 12'h001);
		cyc(1);
	endtask
	task t_format;
		format_select_i <= 1;
		cyc(5);
		mid;
		chk("settling", {11'h000, fmt_settling_o}, 12'h001);
		cyc(7);
		mid;
		chk("A twos", wa, 12'h923);
		chk("settled", {11'h000, fmt_settling_o}, 12'h000);
		cyc(1);
	endtask
	task t_float;
		chan_a_drive_disable_i <= 1;
		samp_a_i <= 12'h456;
		cyc(12);
		mid;
		chk("A float", pa, 12'hZZZ);
		chk("B live", data_b_o, 12'h000);
		chk("B oe", data_b_oe_n_o, 12'h000);
		cyc(1);
		chan_a_drive_disable_i <= 0;
		cyc(8);
		mid;
		chk("A kept", pa, 12'hC56);
		cyc(1);
	endtask
	task t_power;
		powerdown_request_i <= 1;
		cyc(8);
		mid;
		chk("A lost", data_a_o, 12'hFFF);
		chk("pd flag", {11'h000, powered_down_o}, 12'h001);
		chk("B quiet", {11'h000, valid_b_o}, 12'h000);
		cyc(1);
		samp_a_i <= 12'h321;
		powerdown_request_i <= 0;
		cyc(30);
		mid;
		chk("A back", wa, 12'hB21);
		chk("pd off", {11'h000, powered_down_o}, 12'h000);
		chk("B back", {11'h000, valid_b_o}, 12'h001);
	endtask
	initial begin
		cyc(8);
		rst_n_i <= 1;
		t_stream;
		t_format;
		t_float;
		t_power;
		complete_run;
	end
	// About 110 cycles of tests; allow far more
	initial begin
		#30000;
		error_cnt++;
		complete_run;
	end
endmodule

// ---- verification/dac_rx_model.sv ----
// Capturing side of channel A
`timescale 1ns/1ps
module dac_rx_model #(parameter RECOVER = 16) (
	input clk_i, input pd_i, input v_i, input [11:0] p_i,
	output reg [11:0] w_o
);
	int hold_q = 0;
	// Real recovery depends on bypass parts, so the wait is a guess
	always @(posedge clk_i) begin
		hold_q <= pd_i ? RECOVER : hold_q - (hold_q != 0);
		if (hold_q == 0 && v_i)
			w_o <= p_i;
	end
endmodule
